//--- hdl/smca_pkg.sv
package smca_pkg;

	// ----------------------------------------------------------------
	// Array geometry
	// ----------------------------------------------------------------
	localparam int NUM_IN = 10;
	localparam int NUM_MC = 8;
	localparam int NUM_LT = 8;
	localparam int NUM_PT = 9;
	localparam int OE_TERM = 8;
	localparam int NUM_SIG = 18;
	localparam int NUM_LINES = 36;
	localparam int NUM_TERMS = 72;
	localparam int ADR_W = 12;
	localparam int IDX_W = 7;
	localparam int HI_W = 4;
	localparam int LO_W = 32;
	// Dedicated input that doubles as the register clock
	localparam int CLK_PIN = 0;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [11:0] TERM_BASE = 12'h000;
	localparam logic [11:0] TERM_END = 12'h240;
	localparam logic [11:0] CFG_BASE = 12'h400;
	localparam logic [11:0] CFG_END = 12'h420;
	localparam logic [11:0] STAT_ADDR = 12'h500;
	localparam logic [11:0] PIN_ADDR = 12'h504;
	localparam int HALF_BIT = 2;
	localparam int IDX_LSB = 3;
	localparam int CFG_IDX_LSB = 2;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	// Erased array: every line connected, so every term is low
	localparam logic [35:0] MASK_RST = 36'hF_FFFF_FFFF;

	typedef struct packed {
		logic in_only;
		logic act_low;
		logic registered;
	} smca_cfg_t;

	localparam smca_cfg_t CFG_RST = 3'h0;

	typedef struct packed {
		logic oe;
		logic out;
	} smca_pin_t;

endpackage

//--- hdl/smca_sync.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Two-stage synchroniser for pin inputs
// ----------------------------------------------------------------
module smca_sync #(
	parameter int W = 8
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);

	logic [W-1:0] meta_reg;

	// First stage feeds only the second stage
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			meta_reg <= '0;
			o_sync <= '0;
		end else begin
			meta_reg <= i_async;
			o_sync <= meta_reg;
		end
	end

endmodule

//--- hdl/smca_mcell.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// One macrocell: eight logic terms, one enable term, D register
// ----------------------------------------------------------------
module smca_mcell (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [smca_pkg::NUM_LINES-1:0] i_lines,
	input wire logic [smca_pkg::NUM_PT-1:0][smca_pkg::NUM_LINES-1:0] i_masks,
	input wire smca_pkg::smca_cfg_t i_cfg,
	input wire logic i_dev_edge,
	input wire logic i_pin,
	output logic o_fb,
	output logic o_q,
	output smca_pkg::smca_pin_t o_pin
);

	logic [smca_pkg::NUM_PT-1:0] pt;
	logic sum;
	logic comb_reg;
	logic internal;

	// Each term ANDs every connected line
	genvar j;
	generate
		for (j = 0; j < smca_pkg::NUM_PT; j++) begin : g_pt
			assign pt[j] = &(i_lines | ~i_masks[j]);
		end
	endgenerate

	// OR of all eight logic terms, enable term kept apart
	assign sum = |pt[smca_pkg::NUM_LT-1:0];
	assign internal = i_cfg.registered ? o_q : sum;

	// D register steps only on the device clock edge
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_q <= 1'b0;
		end else if (i_dev_edge) begin
			o_q <= sum;
		end
	end

	// Comb feedback passes two flops, comb_reg then o_fb, to break the array loop
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			comb_reg <= 1'b0;
			o_fb <= 1'b0;
			o_pin <= '0;
		end else begin
			comb_reg <= sum;
			// Input-only cells feed the pin back
			o_fb <= i_cfg.in_only ? i_pin : (i_cfg.registered ? o_q : comb_reg);
			o_pin.out <= internal ^ i_cfg.act_low;
			o_pin.oe <= ~i_cfg.in_only & pt[smca_pkg::OE_TERM];
		end
	end

endmodule

//--- hdl/smca_array.sv
`timescale 1ns/1ps

// What this block does
// - Ten inputs, eight configurable I/O pins.
// - Each macrocell ORs eight product terms.
// - Combinational or registered output, polarity, feedback.
// - Thirty-six array lines; terms are wide ANDs.
// - Ninth term per macrocell drives enable.
// - Pin driven only while enable term high.
// - Enable term built freely in array.
// - All eight logic terms stay with OR.
// - Registers step on rising device clock edge.
// - Clock pin also usable as array input.
// - Registers clear to zero at power-up.
// - Enable term may use complement of input.

module smca_array (
	input wire logic I_CLK,
	input wire logic I_RST_N,
	input wire logic I_WB_CYC,
	input wire logic I_WB_STB,
	input wire logic I_WB_WE,
	input wire logic [smca_pkg::ADR_W-1:0] I_WB_ADR,
	input wire logic [3:0] I_WB_SEL,
	input wire logic [31:0] I_WB_DAT,
	input wire logic [smca_pkg::NUM_IN-1:0] I_IN,
	input wire logic [smca_pkg::NUM_MC-1:0] I_IO_IN,
	output logic O_WB_ACK,
	output logic [31:0] O_WB_DAT,
	output logic [smca_pkg::NUM_MC-1:0] O_IO_OUT,
	output logic [smca_pkg::NUM_MC-1:0] O_IO_OE
);

	// ----------------------------------------------------------------
	// Storage and internal nets
	// ----------------------------------------------------------------
	logic [smca_pkg::NUM_LINES-1:0] mask_reg [smca_pkg::NUM_TERMS];
	smca_pkg::smca_cfg_t cfg_reg [smca_pkg::NUM_MC];
	logic ack_reg;
	logic [31:0] rd_reg;
	logic [smca_pkg::NUM_IN-1:0] in_sync;
	logic [smca_pkg::NUM_MC-1:0] io_sync;
	logic dev_clk_prev_reg;
	logic [smca_pkg::NUM_MC-1:0] fb;
	logic [smca_pkg::NUM_MC-1:0] q;
	smca_pkg::smca_pin_t pin [smca_pkg::NUM_MC];
	logic [smca_pkg::NUM_SIG-1:0] sig;
	logic [smca_pkg::NUM_LINES-1:0] lines;
	logic [smca_pkg::NUM_MC-1:0] oe_vec;
	logic [smca_pkg::NUM_MC-1:0] out_vec;

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	// Request seen once; ack then drops for a cycle between requests
	wire req = I_WB_CYC & I_WB_STB & ~ack_reg;
	wire wr_en = req & I_WB_WE;
	wire term_hit = I_WB_ADR < smca_pkg::TERM_END;
	wire cfg_hit = (I_WB_ADR >= smca_pkg::CFG_BASE) && (I_WB_ADR < smca_pkg::CFG_END);
	wire stat_hit = I_WB_ADR[smca_pkg::ADR_W-1:2] == smca_pkg::STAT_ADDR[smca_pkg::ADR_W-1:2];
	wire pin_hit = I_WB_ADR[smca_pkg::ADR_W-1:2] == smca_pkg::PIN_ADDR[smca_pkg::ADR_W-1:2];
	wire hi_half = I_WB_ADR[smca_pkg::HALF_BIT];
	wire [smca_pkg::IDX_W-1:0] raw_idx = I_WB_ADR[smca_pkg::IDX_LSB+:smca_pkg::IDX_W];
	// Out-of-range index never reaches the array
	wire [smca_pkg::IDX_W-1:0] term_idx = term_hit ? raw_idx : '0;
	wire [2:0] cfg_idx = I_WB_ADR[smca_pkg::CFG_IDX_LSB+:3];
	wire wr_term = wr_en & term_hit;
	wire wr_cfg = wr_en & cfg_hit;
	wire [31:0] be_mask = {{8{I_WB_SEL[3]}}, {8{I_WB_SEL[2]}},
		{8{I_WB_SEL[1]}}, {8{I_WB_SEL[0]}}};

	// ----------------------------------------------------------------
	// Read selection
	// ----------------------------------------------------------------
	wire [smca_pkg::NUM_LINES-1:0] rd_mask = mask_reg[term_idx];
	wire [31:0] rd_term = hi_half ?
		{{(32 - smca_pkg::HI_W){1'b0}}, rd_mask[smca_pkg::NUM_LINES-1:smca_pkg::LO_W]} :
		rd_mask[smca_pkg::LO_W-1:0];
	wire [31:0] rd_cfg = {29'h0000_0000, cfg_reg[cfg_idx]};
	// Status shows live register, pin and enable state
	wire [31:0] rd_stat = {8'h00, oe_vec, io_sync, q};
	wire [31:0] rd_pin = {22'h00_0000, in_sync};
	// Unmapped addresses read as zero but still acknowledge
	wire [31:0] rd_next = term_hit ? rd_term :
		cfg_hit ? rd_cfg :
		stat_hit ? rd_stat :
		pin_hit ? rd_pin : 32'h0000_0000;

	// ----------------------------------------------------------------
	// Bus answer
	// ----------------------------------------------------------------
	// Ack one cycle after the request, data registered beside it
	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			ack_reg <= 1'b0;
			rd_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= req;
			if (req) begin
				rd_reg <= rd_next;
			end
		end
	end

	assign O_WB_ACK = ack_reg;
	assign O_WB_DAT = rd_reg;

	// ----------------------------------------------------------------
	// Product term map, one entry per term
	// ----------------------------------------------------------------
	// Low word holds lines 31..0, high word lines 35..32
	genvar t;
	generate
		for (t = 0; t < smca_pkg::NUM_TERMS; t++) begin : g_term
			wire hit = wr_term & (raw_idx == smca_pkg::IDX_W'(t));
			always_ff @(posedge I_CLK) begin
				if (!I_RST_N) begin
					mask_reg[t] <= smca_pkg::MASK_RST;
				end else if (hit && !hi_half) begin
					mask_reg[t][smca_pkg::LO_W-1:0] <=
						(mask_reg[t][smca_pkg::LO_W-1:0] & ~be_mask) | (I_WB_DAT & be_mask);
				end else if (hit && I_WB_SEL[0]) begin
					mask_reg[t][smca_pkg::NUM_LINES-1:smca_pkg::LO_W] <=
						I_WB_DAT[smca_pkg::HI_W-1:0];
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Pin inputs
	// ----------------------------------------------------------------
	// Dedicated inputs, clock pin among them
	smca_sync #(
		.W(smca_pkg::NUM_IN)
	) u_in_sync (
		.i_clk(I_CLK),
		.i_rst_n(I_RST_N),
		.i_async(I_IN),
		.o_sync(in_sync)
	);

	// Levels seen on the I/O pins, used by input-only cells
	smca_sync #(
		.W(smca_pkg::NUM_MC)
	) u_io_sync (
		.i_clk(I_CLK),
		.i_rst_n(I_RST_N),
		.i_async(I_IO_IN),
		.o_sync(io_sync)
	);

	// ----------------------------------------------------------------
	// Device clock edge
	// ----------------------------------------------------------------
	// Edge taken from the synchronised pin; the pin must stay well
	// below half the system rate or edges are missed
	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			dev_clk_prev_reg <= 1'b0;
		end else begin
			dev_clk_prev_reg <= in_sync[smca_pkg::CLK_PIN];
		end
	end

	wire dev_edge = in_sync[smca_pkg::CLK_PIN] & ~dev_clk_prev_reg;

	// ----------------------------------------------------------------
	// Array lines
	// ----------------------------------------------------------------
	// Inputs first, then feedbacks; clock pin stays an ordinary line
	assign sig = {fb, in_sync};

	// True and complement of each signal side by side
	genvar k;
	generate
		for (k = 0; k < smca_pkg::NUM_SIG; k++) begin : g_line
			assign lines[2*k] = sig[k];
			assign lines[2*k+1] = ~sig[k];
		end
	endgenerate

	// ----------------------------------------------------------------
	// Macrocells and their configuration
	// ----------------------------------------------------------------
	// Cell m owns terms m*9 .. m*9+8; the last one is its enable
	genvar m, j;
	generate
		for (m = 0; m < smca_pkg::NUM_MC; m++) begin : g_mc
			logic [smca_pkg::NUM_PT-1:0][smca_pkg::NUM_LINES-1:0] masks;
			wire cfg_wr_hit = wr_cfg & I_WB_SEL[0] & (cfg_idx == 3'(m));

			for (j = 0; j < smca_pkg::NUM_PT; j++) begin : g_sel
				assign masks[j] = mask_reg[m*smca_pkg::NUM_PT+j];
			end

			// Mode bits: registered, active low, input only
			always_ff @(posedge I_CLK) begin
				if (!I_RST_N) begin
					cfg_reg[m] <= smca_pkg::CFG_RST;
				end else if (cfg_wr_hit) begin
					cfg_reg[m] <= I_WB_DAT[2:0];
				end
			end

			smca_mcell u_mcell (
				.i_clk(I_CLK),
				.i_rst_n(I_RST_N),
				.i_lines(lines),
				.i_masks(masks),
				.i_cfg(cfg_reg[m]),
				.i_dev_edge(dev_edge),
				.i_pin(io_sync[m]),
				.o_fb(fb[m]),
				.o_q(q[m]),
				.o_pin(pin[m])
			);

			assign out_vec[m] = pin[m].out;
			assign oe_vec[m] = pin[m].oe;
		end
	endgenerate

	// ----------------------------------------------------------------
	// Pin outputs
	// ----------------------------------------------------------------
	// Both come straight from the macrocell output flops
	assign O_IO_OUT = out_vec;
	assign O_IO_OE = oe_vec;

endmodule

//--- tb/smca_array_sva.sv
`timescale 1ns/1ps
// ----------------------------------------
// Port checker for the array
// ----------------------------------------
module smca_array_chk (
	input wire logic I_CLK,
	input wire logic I_RST_N,
	input wire logic I_WB_CYC,
	input wire logic I_WB_STB,
	input wire logic I_WB_WE,
	input wire logic [11:0] I_WB_ADR,
	input wire logic [9:0] I_IN,
	input wire logic [7:0] I_IO_IN,
	input wire logic O_WB_ACK,
	input wire logic [31:0] O_WB_DAT,
	input wire logic [7:0] O_IO_OUT,
	input wire logic [7:0] O_IO_OE
);
	logic [9:0] in_d;
	logic [7:0] io_d;
	logic [4:0] qt;
	// Any taken request reloads the read register, writes as well
	wire req = I_WB_CYC && I_WB_STB && !O_WB_ACK;
	wire rd = req && !I_WB_WE;
	wire chg = I_IN != in_d || I_IO_IN != io_d || I_WB_CYC && I_WB_WE;
	// Idle count; a seven-deep feedback chain settles within about 17
	always_ff @(posedge I_CLK) begin
		in_d <= I_IN;
		io_d <= I_IO_IN;
		qt <= (!I_RST_N || chg) ? 5'h00 : qt + 5'(qt != 5'h1F);
	end
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_RST_N);
	// Bus handshake, then pin relations
	property p_ack; I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK; endproperty
	a_ack: assert property (p_ack) else $error("ack late");
	property p_pulse; O_WB_ACK |=> !O_WB_ACK; endproperty
	a_pulse: assert property (p_pulse) else $error("ack long");
	property p_cause; O_WB_ACK |-> $past(I_WB_CYC && I_WB_STB); endproperty
	a_cause: assert property (p_cause) else $error("ack unasked");
	property p_hold; !req |=> $stable(O_WB_DAT); endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	property p_unmap; rd && I_WB_ADR == 12'h600 |=> O_WB_DAT == 32'h0; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read");
	property p_clr; $rose(I_RST_N) |->
		O_IO_OE == 8'h00 && O_IO_OUT == 8'h00 && !O_WB_ACK; endproperty
	a_clr: assert property (p_clr) else $error("not clear");
	property p_calm; qt > 5'h14 |-> $stable(O_IO_OUT) && $stable(O_IO_OE); endproperty
	a_calm: assert property (p_calm) else $error("pins moved");
	property p_stat; rd && I_WB_ADR == 12'h500 && qt > 5'h14
		|=> O_WB_DAT[23:16] == $past(O_IO_OE) && O_WB_DAT[15:8] == $past(I_IO_IN); endproperty
	a_stat: assert property (p_stat) else $error("status wrong");
endmodule

bind smca_array smca_array_chk chk_u (.I_CLK, .I_RST_N, .I_WB_CYC, .I_WB_STB, .I_WB_WE,
	.I_WB_ADR, .I_IN, .I_IO_IN, .O_WB_ACK, .O_WB_DAT, .O_IO_OUT, .O_IO_OE);

//--- tb/smca_board.sv
`timescale 1ns/1ps
// ----------------------------------------
// Board side of the I/O pins
// ----------------------------------------
module smca_board (
	input wire logic [7:0] i_drv,
	input wire logic [7:0] i_out,
	input wire logic [7:0] i_oe,
	output logic [7:0] o_pin
);
	// Board yields each pin the device drives, avoiding contention
	assign o_pin = (i_oe & i_out) | (~i_oe & i_drv);
endmodule

//--- tb/smca_array_tb_top.sv
`timescale 1ns/1ps
module smca_array_tb_top;
	logic clk, rst_n, cyc, stb, we, ack;
	logic [3:0] sel;
	logic [11:0] adr;
	logic [31:0] wdat, rdat, seed, dat;
	logic [9:0] inp;
	logic [7:0] drv, io_in, out, oe, q, sum, fb, eo, e_oe, rm;
	logic [35:0] msk [72];
	smca_pkg::smca_cfg_t cfg [8];
	int n_fail, n_compared;

	smca_array dut_u (.I_CLK(clk), .I_RST_N(rst_n), .I_WB_CYC(cyc), .I_WB_STB(stb),
		.I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat), .I_IN(inp),
		.I_IO_IN(io_in), .O_WB_ACK(ack), .O_WB_DAT(dat), .O_IO_OUT(out), .O_IO_OE(oe));
	smca_board brd_u (.i_drv(drv), .i_out(out), .i_oe(oe), .o_pin(io_in));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic stop_test();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] e, input logic [31:0] g, input string s);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED %0t %s", $time, s);
		end
	endtask

	// Classic single cycle; waits for ack under a bound
	task automatic wb(input logic w, input int a, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= 12'(a);
		wdat <= d;
		sel <= 4'hF;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (n >= 50) begin
			n_fail++;
			stop_test();
		end
		rdat = dat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr_term(input int t, input logic [35:0] v);
		wb(1'b1, 8 * t, v[31:0]);
		wb(1'b1, 8 * t + 4, {28'h0, v[35:32]});
	endtask

	// ----------------------------------------
	// Reference model of the array
	// ----------------------------------------
	function automatic logic term(input int t);
		logic [17:0] s;
		logic [35:0] ln;
		s = {fb, inp};
		for (int k = 0; k < 18; k++)
			ln[2 * k +: 2] = {~s[k], s[k]};
		return &(ln | ~msk[t]);
	endfunction

	// Iterated to a fixed point; feedback only flows to later cells
	task automatic check_pins();
		repeat (40) @(posedge clk);
		repeat (9) begin
			for (int m = 0; m < 8; m++) begin
				sum[m] = 1'b0;
				for (int k = 0; k < 8; k++)
					sum[m] = sum[m] | term(9 * m + k);
				fb[m] = cfg[m].in_only ? drv[m] : cfg[m].registered ? q[m] : sum[m];
				eo[m] = (cfg[m].registered ? q[m] : sum[m]) ^ cfg[m].act_low;
				e_oe[m] = !cfg[m].in_only && term(9 * m + 8);
				rm[m] = cfg[m].registered;
			end
		end
		chk(e_oe, oe, "enable");
		chk(eo & e_oe, out & e_oe, "pin value");
		wb(1'b0, 'h500, 0);
		chk(q & rm, rdat[7:0] & rm, "register");
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		seed = 32'h9;
		{rst_n, cyc, stb, we, sel, adr, wdat, inp, drv, q, fb} = '0;
		n_fail = 0;
		n_compared = 0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		wb(1'b0, 'h000, 0);
		chk(32'hFFFFFFFF, rdat, "mask low");
		wb(1'b0, 'h004, 0);
		chk(32'hF, rdat, "mask high");
		wb(1'b0, 'h400, 0);
		chk(32'h0, rdat, "cfg");
		wb(1'b1, 'h600, 32'h5A5A5A5A);
		wb(1'b0, 'h600, 0);
		chk(32'h0, rdat, "unmapped");
		wb(1'b0, 'h500, 0);
		chk(32'h0, rdat, "status");
		$display("reset test done");
		for (int m = 0; m < 8; m++) begin
			wdat = rnd();
			cfg[m] = smca_pkg::smca_cfg_t'({wdat[2:0] == 3'h0, wdat[4:3]});
			wb(1'b1, 'h400 + 4 * m, {29'h0, cfg[m]});
			for (int k = 0; k < 9; k++)
				msk[9 * m + k] = {36{1'b1}};
			msk[9 * m + wdat[7:5]] = 36'h1 << (2 + rnd() % (18 + 2 * m));
			msk[9 * m + (wdat[7:5] ^ 3'h4)] = 36'h1 << (2 + rnd() % (18 + 2 * m));
			case (wdat[9:8])
				2'h0: msk[9 * m + 8] = 36'h0;
				2'h1: msk[9 * m + 8] = 36'h1 << (3 + 2 * (rnd() % 9));
				default: ;
			endcase
			for (int k = 0; k < 9; k++)
				wr_term(9 * m + k, msk[9 * m + k]);
		end
		for (int r = 0; r < 12; r++) begin
			wdat = rnd();
			inp <= {wdat[9:1], 1'b0};
			drv <= wdat[17:10];
			check_pins();
			q = sum;
			inp <= {inp[9:1], 1'b1};
			check_pins();
		end
		$display("random test done");
		rst_n <= 1'b0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		chk(8'h00, oe, "enable cleared");
		wb(1'b0, 'h500, 0);
		chk(8'h00, rdat[7:0], "register cleared");
		$display("second reset test done");
		stop_test();
	end
endmodule
